// ---- design/pp_params.svh ----
// Constants for the parallel programming port, both ends
`ifndef PP_PARAMS_SVH
`define PP_PARAMS_SVH
`define LM_ADDR 2'h0
`define LM_DATA 2'h1
`define LM_CMD 2'h2
`define CMD_NOP 8'h00
`define CMD_FLASH_RD 8'h02
`define CMD_EE_RD 8'h03
`define CMD_FUSE_LOCK_RD 8'h04
`define CMD_SIG_RD 8'h08
`define CMD_FLASH_WR 8'h10
`define CMD_EE_WR 8'h11
`define CMD_LOCK_WR 8'h20
`define CMD_FUSE_WR 8'h40
`define WORD_BITS 6
`define FLASH_PAGES_BITS 7
`define EE_WORD_BITS 2
`define EE_ADDR_BITS 9
`define PROG_TIME_US 4
`define CLK_MHZ 250
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define BUSY_W 20
`define FUSE_LO_RST 8'h62
`define FUSE_HI_RST 8'hdf
`define FUSE_EXT_RST 8'hff
`define LOCK_RST 8'hff
`define LOCK_BOOT_MASK 8'h3c
`define LOCK_MODE_MASK 8'h03
`define SIG0 8'h11
`define SIG1 8'h22
`define SIG2 8'h33
`define CAL_BYTE 8'h80
`define STROBE_W 4
`define AXI_CMD 4'h0
`define AXI_ADDR 4'h4
`define AXI_DATA 4'h8
`define AXI_GO 4'hc
`define AXI_STAT 4'h0
`endif

// ---- design/pp_pkg.sv ----
// Types shared by both ends of the programming port
package pp_pkg;
    typedef enum logic [2:0] {
        OP_CMD, OP_ADDR_LO, OP_ADDR_HI, OP_DATA_LO, OP_DATA_HI,
        OP_LATCH, OP_WRITE, OP_READ
    } op_t;
endpackage

// ---- design/pp_if.sv ----
// Pin bundle joining programmer and device
interface pp_if;
    logic load_mode_hi;
    logic load_mode_lo;
    logic byte_select_one;
    logic byte_select_two;
    logic load_strobe;
    logic page_latch_strobe;
    logic write_n;
    logic out_en_n;
    logic ready_busy_out;
    logic [7:0] data_to_dev;
    logic [7:0] data_from_dev;
    logic data_oe_n;
    modport device (
        input load_mode_hi, load_mode_lo, byte_select_one,
        byte_select_two, load_strobe, page_latch_strobe, write_n,
        out_en_n, data_to_dev,
        output ready_busy_out, data_from_dev, data_oe_n
    );
    modport programmer (
        output load_mode_hi, load_mode_lo, byte_select_one,
        byte_select_two, load_strobe, page_latch_strobe, write_n,
        out_en_n, data_to_dev,
        input ready_busy_out, data_from_dev, data_oe_n
    );
endinterface

// ---- design/pp_device.sv ----
// Device end: command register, page buffers, memories, fuses, locks
`include "pp_params.svh"
module pp_device
    import pp_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Programming pins
    pp_if.device pins
);
    localparam int FW = 1 << (`WORD_BITS + `FLASH_PAGES_BITS);
    localparam int PW = 1 << `WORD_BITS;
    localparam int EW = 1 << `EE_ADDR_BITS;
    localparam int EP = 1 << `EE_WORD_BITS;

    // Two-flop synchronisers for every pin input
    logic [14:0] s1, s2;
    logic [14:0] raw;
    assign raw = {pins.load_mode_hi, pins.load_mode_lo,
        pins.byte_select_one, pins.byte_select_two, pins.load_strobe,
        pins.page_latch_strobe, pins.write_n, pins.out_en_n,
        pins.data_to_dev[6:0]};
    logic d7_1, d7_2;
    always_ff @(posedge aclk) begin
        s1 <= raw;
        s2 <= s1;
        d7_1 <= pins.data_to_dev[7];
        d7_2 <= d7_1;
    end
    logic [1:0] lmode;
    logic bs1, bs2, xs, pl, wr_n, oe_n;
    logic [7:0] din;
    assign lmode = s2[14:13];
    assign bs1 = s2[12];
    assign bs2 = s2[11];
    assign xs = s2[10];
    assign pl = s2[9];
    assign wr_n = s2[8];
    assign oe_n = s2[7];
    assign din = {d7_2, s2[6:0]};

    logic xs_d, pl_d, wr_d;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xs_d <= 1'b0;
            pl_d <= 1'b0;
            wr_d <= 1'b1;
        end else begin
            xs_d <= xs;
            pl_d <= pl;
            wr_d <= wr_n;
        end
    end
    logic load_ev, latch_ev, write_ev;
    assign load_ev = xs && !xs_d;
    assign latch_ev = pl && !pl_d;
    assign write_ev = !wr_n && wr_d;

    logic [7:0] cmd, addr_lo, addr_hi, data_lo, data_hi;
    logic [`BUSY_W-1:0] busy_cnt;
    logic busy;
    assign busy = busy_cnt != '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= `CMD_NOP;
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
            data_lo <= 8'hff;
            data_hi <= 8'hff;
        end else if (load_ev && !busy) begin
            unique case (lmode)
                `LM_CMD: if (!bs1) cmd <= din;
                `LM_ADDR: if (bs1) addr_hi <= din; else addr_lo <= din;
                `LM_DATA: if (bs1) data_hi <= din; else data_lo <= din;
                default: ;
            endcase
        end
    end

    logic [`WORD_BITS-1:0] word_in_page_bits;
    logic [`FLASH_PAGES_BITS-1:0] page_index_bits;
    logic [`WORD_BITS+`FLASH_PAGES_BITS-1:0] flash_addr;
    logic [`EE_ADDR_BITS-1:0] ee_addr;
    logic [15:0] full_addr;
    assign word_in_page_bits = addr_lo[`WORD_BITS-1:0];
    assign full_addr = {addr_hi, addr_lo};
    assign flash_addr = full_addr[`WORD_BITS+`FLASH_PAGES_BITS-1:0];
    assign page_index_bits = flash_addr[`WORD_BITS+`FLASH_PAGES_BITS-1:
        `WORD_BITS];
    assign ee_addr = full_addr[`EE_ADDR_BITS-1:0];

    logic [15:0] page_buf [PW];
    logic [7:0] ee_buf [EP];
    logic [15:0] flash [FW];
    logic [7:0] eeprom [EW];
    logic [7:0] fuse_lo, fuse_hi, fuse_ext, lock;
    logic [1:0] pend; // 1 flash, 2 eeprom
    logic wr_armed;
    logic [`EE_ADDR_BITS-1:0] ee_base;
    // Only programming commands may open a busy span
    logic prog_cmd;
    assign prog_cmd = cmd == `CMD_FLASH_WR || (cmd == `CMD_EE_WR && !bs1)
        || cmd == `CMD_FUSE_WR || cmd == `CMD_LOCK_WR;

    always_ff @(posedge aclk) begin
        if (latch_ev && !busy) begin
            if (cmd == `CMD_EE_WR) begin
                ee_buf[ee_addr[`EE_WORD_BITS-1:0]] <= data_lo;
            end else if (bs1) begin
                page_buf[word_in_page_bits] <= {data_hi, data_lo};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_cnt <= '0;
            pend <= 2'h0;
            wr_armed <= 1'b0;
            ee_base <= '0;
        end else if (load_ev && lmode == `LM_CMD && !bs1 && !busy) begin
            // No-op disarms the write strobe until a real command
            wr_armed <= din != `CMD_NOP;
            pend <= 2'h0;
        end else if (write_ev && !busy && wr_armed && prog_cmd) begin
            busy_cnt <= `BUSY_W'(`PROG_CYCLES);
            ee_base <= ee_addr;
            if (cmd == `CMD_FLASH_WR) begin
                pend <= 2'h1;
            end else if (cmd == `CMD_EE_WR && !bs1) begin
                pend <= 2'h2;
            end
        end else if (busy) begin
            busy_cnt <= busy_cnt - `BUSY_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (busy_cnt == `BUSY_W'(1) && pend == 2'h1) begin
            for (int i = 0; i < PW; i++) begin
                flash[{page_index_bits, `WORD_BITS'(i)}] <= page_buf[i];
            end
        end
        if (busy_cnt == `BUSY_W'(1) && pend == 2'h2) begin
            for (int i = 0; i < EP; i++) begin
                eeprom[{ee_base[`EE_ADDR_BITS-1:`EE_WORD_BITS],
                    `EE_WORD_BITS'(i)}] <= ee_buf[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse_lo <= `FUSE_LO_RST;
            fuse_hi <= `FUSE_HI_RST;
            fuse_ext <= `FUSE_EXT_RST;
            lock <= `LOCK_RST;
        end else if (write_ev && !busy && wr_armed) begin
            if (cmd == `CMD_FUSE_WR) begin
                if (bs2) fuse_ext <= data_lo;
                else if (bs1) fuse_hi <= data_lo;
                else fuse_lo <= data_lo;
            end else if (cmd == `CMD_LOCK_WR) begin
                if ((lock & `LOCK_MODE_MASK) == 8'h00) begin
                    lock <= lock & (data_lo | `LOCK_BOOT_MASK);
                end else begin
                    lock <= lock & data_lo;
                end
            end
        end
    end

    logic [7:0] rd;
    always_comb begin
        rd = 8'hff;
        unique case (cmd)
            `CMD_FLASH_RD: rd = bs1 ? flash[flash_addr][15:8] :
                flash[flash_addr][7:0];
            `CMD_EE_RD: rd = eeprom[ee_addr];
            `CMD_FUSE_LOCK_RD: begin
                unique case ({bs2, bs1})
                    2'h0: rd = fuse_lo;
                    2'h3: rd = fuse_hi;
                    2'h2: rd = fuse_ext;
                    default: rd = lock;
                endcase
            end
            `CMD_SIG_RD: begin
                if (bs1) rd = `CAL_BYTE;
                else if (addr_lo == 8'h00) rd = `SIG0;
                else if (addr_lo == 8'h01) rd = `SIG1;
                else if (addr_lo == 8'h02) rd = `SIG2;
            end
            default: rd = 8'hff;
        endcase
    end

    logic [7:0] dout;
    logic drive_n;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout <= 8'h00;
            drive_n <= 1'b1;
        end else begin
            dout <= rd;
            drive_n <= oe_n;
        end
    end
    assign pins.data_from_dev = dout;
    assign pins.data_oe_n = drive_n;
    assign pins.ready_busy_out = !busy;
endmodule

// ---- design/pp_programmer.sv ----
// Programmer end: AXI4-Lite registers drive pin sequences
`include "pp_params.svh"
module pp_programmer
    import pp_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Programming pins
    pp_if.programmer pins
);
    typedef enum logic [1:0] {IDLE, SETUP, PULSE, WAITB} st_t;
    st_t st;
    logic [7:0] byte_val;
    logic [2:0] sel; // {bs2, bs1, lmode_lo-ignored}
    logic [7:0] rd_byte;
    logic [3:0] cnt;
    logic [2:0] op;
    logic rdy1, rdy2;
    logic [7:0] din1, din2;
    always_ff @(posedge aclk) begin
        rdy1 <= pins.ready_busy_out;
        rdy2 <= rdy1;
        din1 <= pins.data_from_dev;
        din2 <= din1;
    end

    logic aw_ok, w_ok;
    assign awready = !bvalid && !aw_ok;
    assign wready = !bvalid && !w_ok;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            bvalid <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_ok <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_ok <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (aw_ok && w_ok) begin
                aw_ok <= 1'b0;
                w_ok <= 1'b0;
                bvalid <= 1'b1;
            end
            if (bvalid && bready) bvalid <= 1'b0;
        end
    end
    assign bresp = 2'h0;
    logic wr_go;
    assign wr_go = aw_ok && w_ok && aw_addr == `AXI_GO && st == IDLE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_val <= 8'h00;
            sel <= 3'h0;
            op <= 3'h0;
        end else if (aw_ok && w_ok) begin
            if (aw_addr == `AXI_DATA && w_strb[0]) byte_val <= w_data[7:0];
            if (aw_addr == `AXI_CMD && w_strb[0]) begin
                op <= w_data[2:0];
                sel <= w_data[6:4];
            end
        end
    end

    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= {22'h0, st != IDLE, rdy2, rd_byte};
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
    assign rresp = 2'h0;

    op_t opx;
    assign opx = op_t'(op);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= IDLE;
            cnt <= 4'h0;
            rd_byte <= 8'h00;
            pins.load_mode_hi <= 1'b0;
            pins.load_mode_lo <= 1'b0;
            pins.byte_select_one <= 1'b0;
            pins.byte_select_two <= 1'b0;
            pins.load_strobe <= 1'b0;
            pins.page_latch_strobe <= 1'b0;
            pins.write_n <= 1'b1;
            pins.out_en_n <= 1'b1;
            pins.data_to_dev <= 8'h00;
        end else begin
            unique case (st)
                IDLE: if (wr_go) begin
                    st <= SETUP;
                    cnt <= 4'h0;
                    pins.data_to_dev <= byte_val;
                    pins.byte_select_two <= sel[2];
                    pins.byte_select_one <= sel[1];
                    unique case (opx)
                        OP_CMD: {pins.load_mode_hi, pins.load_mode_lo} <=
                            `LM_CMD;
                        OP_ADDR_LO, OP_ADDR_HI:
                            {pins.load_mode_hi, pins.load_mode_lo} <=
                            `LM_ADDR;
                        default: {pins.load_mode_hi, pins.load_mode_lo} <=
                            `LM_DATA;
                    endcase
                    if (opx == OP_READ) pins.out_en_n <= 1'b0;
                end
                SETUP: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == 4'(`STROBE_W)) begin
                        st <= PULSE;
                        cnt <= 4'h0;
                        unique case (opx)
                            OP_LATCH: pins.page_latch_strobe <= 1'b1;
                            OP_WRITE: pins.write_n <= 1'b0;
                            OP_READ: ;
                            default: pins.load_strobe <= 1'b1;
                        endcase
                    end
                end
                PULSE: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == 4'(`STROBE_W)) begin
                        st <= WAITB;
                        cnt <= 4'h0;
                        if (opx == OP_READ) rd_byte <= din2;
                        pins.load_strobe <= 1'b0;
                        pins.page_latch_strobe <= 1'b0;
                        pins.write_n <= 1'b1;
                    end
                end
                WAITB: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == 4'(`STROBE_W) && rdy2) begin
                        st <= IDLE;
                        pins.out_en_n <= 1'b1;
                    end
                end
                default: st <= IDLE;
            endcase
        end
    end
endmodule

// ---- sim/pp_port_props.sv ----
// Concurrent checks on the pins between programmer and device
`include "pp_params.svh"
module pp_port_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Programmer to device
    input wire logic load_mode_hi,
    input wire logic load_mode_lo,
    input wire logic byte_select_one,
    input wire logic byte_select_two,
    input wire logic load_strobe,
    input wire logic page_latch_strobe,
    input wire logic write_n,
    input wire logic out_en_n,
    input wire logic [7:0] data_to_dev,
    // Device to programmer
    input wire logic ready_busy_out,
    input wire logic [7:0] data_from_dev,
    input wire logic data_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cmd, addr_lo, wr_age;
    logic [10:0] low_cnt;
    logic strobe_q, ld, prog_cmd, rd_cmd;
    assign ld = load_strobe && !strobe_q && !byte_select_one;
    assign prog_cmd = cmd == `CMD_FLASH_WR || cmd == `CMD_EE_WR ||
        cmd == `CMD_FUSE_WR || cmd == `CMD_LOCK_WR;
    assign rd_cmd = cmd == `CMD_FLASH_RD || cmd == `CMD_EE_RD ||
        cmd == `CMD_FUSE_LOCK_RD || cmd == `CMD_SIG_RD;
    always_ff @(posedge aclk) begin
        strobe_q <= aresetn && load_strobe;
    end
    // Shadow of the command and address low byte, taken at strobe rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= `CMD_NOP;
        end else if (ld && load_mode_hi && !load_mode_lo) begin
            cmd <= data_to_dev;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_lo <= 8'h00;
        end else if (ld && !load_mode_hi && !load_mode_lo) begin
            addr_lo <= data_to_dev;
        end
    end
    always_ff @(posedge aclk) begin
        low_cnt <= (!aresetn || ready_busy_out) ? 11'h0 : low_cnt + 11'h1;
    end
    // Saturates so a long idle spell never wraps back into the window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_age <= 8'hff;
        end else if (!write_n) begin
            wr_age <= 8'h00;
        end else if (wr_age != 8'hff) begin
            wr_age <= wr_age + 8'h01;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_sig_read;
        (cmd == `CMD_SIG_RD && addr_lo == 8'h00 && !data_oe_n &&
            !byte_select_one)[*2];
    endsequence
    property p_busy_start;
        $fell(write_n) && prog_cmd |-> ##[1:8] !ready_busy_out;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy missing after program strobe");
    property p_busy_cause;
        $fell(ready_busy_out) |-> wr_age <= 8'h08;
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy without a write strobe");
    property p_busy_len;
        $rose(ready_busy_out) |-> low_cnt >= 11'h3de && low_cnt <= 11'h3f2;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy span length wrong");
    property p_nop_quiet;
        $fell(write_n) && cmd == `CMD_NOP |-> ready_busy_out[*8];
    endproperty
    a_nop_quiet: assert property (p_nop_quiet)
        else $error("write strobe acted after no-op command");
    property p_wait_ready;
        !ready_busy_out |-> !load_strobe && !page_latch_strobe &&
            !$fell(write_n);
    endproperty
    a_wait_ready: assert property (p_wait_ready)
        else $error("strobe given while device busy");
    property p_read_drive;
        $fell(out_en_n) && rd_cmd |-> ##[1:6] !data_oe_n;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("device did not drive data on read");
    property p_read_release;
        $rose(out_en_n) |-> ##[1:6] data_oe_n;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("device kept driving data");
    property p_sig_byte;
        s_sig_read |-> data_from_dev == `SIG0;
    endproperty
    a_sig_byte: assert property (p_sig_byte)
        else $error("wrong first signature byte");
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench: AXI register calls drive both ends
`include "pp_params.svh"
module testbench import pp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0, rdata, st;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] sig [3] = '{`SIG0, `SIG1, `SIG2};
    logic [15:0] fw [2] = '{16'h5aa5, 16'h3cc3};
    logic [7:0] ew [2] = '{8'hc3, 8'h96};
    logic [7:0] fz [4] = '{8'h12, 8'h34, 8'h56, 8'hf0};
    logic [1:0] fs [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    int failures = 0;
    int n_checks = 0;
    int polls = 0;
    pp_if pif();
    pp_device i_pp_device (.aclk(aclk), .aresetn(aresetn), .pins(pif));
    pp_programmer i_pp_programmer (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .pins(pif));
    pp_port_props i_pp_port_props (
        .aclk(aclk), .aresetn(aresetn),
        .load_mode_hi(pif.load_mode_hi), .load_mode_lo(pif.load_mode_lo),
        .byte_select_one(pif.byte_select_one),
        .byte_select_two(pif.byte_select_two),
        .load_strobe(pif.load_strobe), .write_n(pif.write_n),
        .page_latch_strobe(pif.page_latch_strobe),
        .out_en_n(pif.out_en_n), .data_to_dev(pif.data_to_dev),
        .ready_busy_out(pif.ready_busy_out),
        .data_from_dev(pif.data_from_dev), .data_oe_n(pif.data_oe_n));
    always #2 aclk = ~aclk;
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Handshake flags are sampled mid-cycle, where they are settled
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_t, w_t, done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            done = bvalid;
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        logic ar_t, done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ar_t = arvalid && arready;
            done = rvalid;
            d = rdata;
            @(posedge aclk);
            if (ar_t) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    // One pin operation, then poll until the programmer is idle again
    task automatic do_op(input op_t op, input logic b2, input logic b1,
        input logic [7:0] d);
        axi_wr(`AXI_CMD, {25'h0, b2, b1, 2'h0, op});
        axi_wr(`AXI_DATA, {24'h0, d});
        axi_wr(`AXI_GO, 32'h1);
        st = 32'h200;
        polls = 0;
        while (st[9] !== 1'b0) begin
            polls++;
            axi_rd(`AXI_STAT, st);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        do_op(OP_CMD, 1'b0, 1'b0, c);
    endtask
    task automatic rd_chk(input logic b2, input logic b1,
        input logic [7:0] e, input string what);
        do_op(OP_READ, b2, b1, 8'h00);
        check(what, st[7:0], e);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        cmd(`CMD_FUSE_LOCK_RD);
        rd_chk(1'b0, 1'b0, `FUSE_LO_RST, "fuse_lo");
        rd_chk(1'b1, 1'b1, `FUSE_HI_RST, "fuse_hi");
        rd_chk(1'b1, 1'b0, `FUSE_EXT_RST, "fuse_ext");
        rd_chk(1'b0, 1'b1, `LOCK_RST, "lock");
        axi_rd(4'h4, st);
        check("idle_status", {6'h0, st[9:8]}, 8'h01);
        $display("test reset_readback done");
        cmd(`CMD_SIG_RD);
        for (int i = 0; i < 3; i++) begin
            do_op(OP_ADDR_LO, 1'b0, 1'b0, 8'(i));
            rd_chk(1'b0, 1'b0, sig[i], "signature");
        end
        do_op(OP_ADDR_LO, 1'b0, 1'b0, 8'h00);
        rd_chk(1'b0, 1'b1, `CAL_BYTE, "calibration");
        $display("test signature done");
        cmd(`CMD_FLASH_WR);
        for (int i = 0; i < 2; i++) begin
            do_op(OP_ADDR_LO, 1'b0, 1'b0, 8'h45 + 8'(i));
            do_op(OP_DATA_LO, 1'b0, 1'b0, fw[i][7:0]);
            do_op(OP_DATA_HI, 1'b0, 1'b1, fw[i][15:8]);
            do_op(OP_LATCH, 1'b0, 1'b1, 8'h00);
        end
        do_op(OP_ADDR_HI, 1'b0, 1'b1, 8'h01);
        do_op(OP_WRITE, 1'b0, 1'b0, 8'h00);
        check("ready_after_write", {7'h0, st[8]}, 8'h01);
        check("busy_span", {7'h0, polls > 100}, 8'h01);
        cmd(`CMD_NOP);
        do_op(OP_WRITE, 1'b0, 1'b0, 8'h00);
        check("ready_after_nop", {7'h0, st[8]}, 8'h01);
        check("nop_no_busy", {7'h0, polls < 20}, 8'h01);
        cmd(`CMD_FLASH_RD);
        do_op(OP_ADDR_HI, 1'b0, 1'b1, 8'h01);
        for (int i = 0; i < 2; i++) begin
            do_op(OP_ADDR_LO, 1'b0, 1'b0, 8'h45 + 8'(i));
            rd_chk(1'b0, 1'b0, fw[i][7:0], "flash_lo");
            rd_chk(1'b0, 1'b1, fw[i][15:8], "flash_hi");
        end
        $display("test flash done");
        cmd(`CMD_EE_WR);
        do_op(OP_ADDR_HI, 1'b0, 1'b1, 8'h01);
        for (int i = 0; i < 2; i++) begin
            do_op(OP_ADDR_LO, 1'b0, 1'b0, 8'h04 + 8'(i));
            do_op(OP_DATA_LO, 1'b0, 1'b0, ew[i]);
            do_op(OP_LATCH, 1'b0, 1'b1, 8'h00);
        end
        do_op(OP_WRITE, 1'b0, 1'b0, 8'h00);
        check("ee_busy_span", {7'h0, polls > 100}, 8'h01);
        cmd(`CMD_EE_RD);
        do_op(OP_ADDR_HI, 1'b0, 1'b1, 8'h01);
        for (int i = 0; i < 2; i++) begin
            do_op(OP_ADDR_LO, 1'b0, 1'b0, 8'h04 + 8'(i));
            rd_chk(1'b0, 1'b0, ew[i], "eeprom");
        end
        $display("test eeprom done");
        cmd(`CMD_FUSE_WR);
        for (int i = 0; i < 4; i++) begin
            do_op(OP_DATA_LO, 1'b0, 1'b0, fz[i]);
            do_op(OP_WRITE, fs[i][1], fs[i][0], 8'h00);
        end
        cmd(`CMD_FUSE_LOCK_RD);
        rd_chk(1'b0, 1'b0, fz[3], "fuse_lo");
        rd_chk(1'b1, 1'b1, fz[1], "fuse_hi");
        rd_chk(1'b1, 1'b0, fz[2], "fuse_ext");
        $display("test fuse done");
        cmd(`CMD_LOCK_WR);
        do_op(OP_DATA_LO, 1'b0, 1'b0, 8'hfc);
        do_op(OP_WRITE, 1'b0, 1'b0, 8'h00);
        do_op(OP_DATA_LO, 1'b0, 1'b0, 8'h83);
        do_op(OP_WRITE, 1'b0, 1'b0, 8'h00);
        cmd(`CMD_FUSE_LOCK_RD);
        rd_chk(1'b0, 1'b1, 8'hbc, "lock");
        $display("test lock done");
        wrap_up();
    end
endmodule
